/* hw/wave_pkg.sv */
package wave_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [2:0] OFF_CTRL_A   = 3'h0;   // waveform_control_a
    localparam logic [2:0] OFF_CTRL_B   = 3'h1;   // wave_mode_hi_bit, force strobes
    localparam logic [2:0] OFF_COUNT    = 3'h2;   // count_value
    localparam logic [2:0] OFF_CMP_A    = 3'h3;   // cmp_value_a
    localparam logic [2:0] OFF_CMP_B    = 3'h4;   // cmp_value_b
    localparam logic [2:0] OFF_STATUS   = 3'h5;   // overflow flag, write one to clear
    localparam logic [2:0] OFF_PRESCALE = 3'h6;   // prescale select and async select
    localparam logic [2:0] OFF_DIR      = 3'h7;   // pin direction bits

    // ********************************************************
    // Field positions and reset values
    // ********************************************************
    localparam int        POS_ACT_A   = 6;
    localparam int        POS_ACT_B   = 4;
    localparam int        POS_MODE_LO = 0;
    localparam int        POS_MODE_HI = 3;
    localparam int        POS_FORCE_A = 7;
    localparam int        POS_FORCE_B = 6;
    localparam int        POS_ASYNC   = 3;
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_A_WMASK = 8'hf3;  // Bits 3:2 read as zero

    // ********************************************************
    // Counter constants
    // ********************************************************
    localparam logic [7:0] BOTTOM   = 8'h00;
    localparam logic [7:0] MAX      = 8'hff;
    localparam int         PERIOD_FIXED = 510;  // Timer ticks per dual-slope period at MAX
    localparam int         PRESCALE_MAX = 1024;

    // Output action codes
    localparam logic [1:0] ACT_OFF    = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_SET    = 2'h3;

    typedef enum logic [1:0] {
        KIND_NORMAL,
        KIND_CTC,
        KIND_FAST,
        KIND_DUAL
    } kind_t;

    // Per-tick counter event bundle handed to each channel
    typedef struct packed {
        logic       tick;      // timer clock enable
        logic       dir_down;  // counting direction at this count
        logic       at_top;    // counter equals ceiling
        logic       at_bottom; // counter at bottom (fast: reload)
        logic [7:0] count;
        logic [7:0] top;
    } cnt_evt_t;

endpackage

/* hw/wave_prescaler.sv */
`timescale 1ns/1ns
// Produces the timer tick enable from the system clock
module wave_prescaler #(
    parameter int DIV_MAX = wave_pkg::PRESCALE_MAX
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Control
    input  wire logic [2:0] sel_i,
    input  wire logic       async_i,
    input  wire logic       osc_tick_i,
    // Enable out
    output logic            tick_o
);
    logic [9:0] div_q;
    logic       pre_tick;

    // ********************************************************
    // Free running divider
    // ********************************************************
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            div_q <= 10'h000;
        else
            div_q <= div_q + 10'h001;
    end

    // Select one of the divide ratios; 0 stops the timer unless async_i is set
    always_comb
    begin
        case (sel_i)
            3'h1:    pre_tick = 1'b1;
            3'h2:    pre_tick = (div_q[2:0] == 3'h7);
            3'h3:    pre_tick = (div_q[4:0] == 5'h1f);
            3'h4:    pre_tick = (div_q[5:0] == 6'h3f);
            3'h5:    pre_tick = (div_q[6:0] == 7'h7f);
            3'h6:    pre_tick = (div_q[7:0] == 8'hff);
            3'h7:    pre_tick = (div_q == 10'h3ff);
            default: pre_tick = 1'b0;
        endcase
    end

    // Async source: oscillator tick already sampled into this domain
    assign tick_o = async_i ? osc_tick_i : pre_tick;
endmodule

/* hw/wave_channel.sv */
`timescale 1ns/1ns
// One compare output channel: match detection and output action
module wave_channel #(
    parameter bit IS_A = 1'b1
) (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // Counter events and setup
    input  wire wave_pkg::cnt_evt_t evt_i,
    input  wire wave_pkg::kind_t    kind_i,
    input  wire logic               mode_hi_i,
    input  wire logic [1:0]         act_i,
    input  wire logic [7:0]         cmp_i,
    input  wire logic               force_i,
    input  wire logic               block_i,
    // Output level
    output logic                    out_o
);
    logic       match;
    logic       at_top_hit;
    logic       out_d;
    logic       out_q;
    logic [7:0] cmp_prev_q;
    logic       up_lvl;

    // Full 8-bit compare, blocked on the tick after a counter write
    assign match = evt_i.tick && !block_i && (evt_i.count == cmp_i);
    assign at_top_hit = (cmp_i == evt_i.top) && act_i[1];
    assign up_lvl = (act_i == wave_pkg::ACT_SET);  // Level after up-count match

    // ********************************************************
    // Output action
    // ********************************************************
    always_comb
    begin
        out_d = out_q;
        if (kind_i == wave_pkg::KIND_DUAL)
        begin
            if (act_i == wave_pkg::ACT_TOGGLE)
            begin
                if (match && IS_A && mode_hi_i)
                    out_d = !out_q;
            end
            else if (act_i[1] && evt_i.tick)
            begin
                if (cmp_prev_q == wave_pkg::MAX && cmp_i != wave_pkg::MAX
                    && evt_i.at_bottom)
                    out_d = up_lvl;
                else if (at_top_hit && evt_i.at_top)
                    out_d = !up_lvl;
                else if (at_top_hit)
                    out_d = out_q;
                // Bottom opens the up slope, so a compare at bottom keeps the up level
                else if (match && (!evt_i.dir_down || evt_i.at_bottom))
                    out_d = up_lvl;
                else if (match)
                    out_d = !up_lvl;
                else if (evt_i.at_top && evt_i.count > cmp_i)
                    out_d = up_lvl;
            end
        end
        else if (kind_i == wave_pkg::KIND_FAST)
        begin
            if (act_i == wave_pkg::ACT_TOGGLE)
            begin
                if (match && IS_A && mode_hi_i)
                    out_d = !out_q;
            end
            else if (act_i[1] && evt_i.tick)
            begin
                if (at_top_hit)
                    out_d = evt_i.at_top ? !up_lvl : out_q;
                else if (match)
                    out_d = up_lvl;
                else if (evt_i.at_top)
                    out_d = !up_lvl;
            end
        end
        else if (match || force_i)
        begin
            case (act_i)
                wave_pkg::ACT_TOGGLE: out_d = !out_q;
                wave_pkg::ACT_CLEAR:  out_d = 1'b0;
                wave_pkg::ACT_SET:    out_d = 1'b1;
                default:              out_d = out_q;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            out_q <= 1'b0;
        else
            out_q <= out_d;
    end

    // Last compare value seen at a tick, to spot a move away from MAX
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            cmp_prev_q <= 8'h00;
        else if (evt_i.tick)
            cmp_prev_q <= cmp_i;
    end

    assign out_o = out_q;
endmodule

/* hw/wave_timer.sv */
`timescale 1ns/1ns

module wave_timer (
    // Clock and reset
    input  wire logic       SYS_CLK_I,
    input  wire logic       RST_I,
    // Register port
    input  wire logic [2:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    // Oscillator tick, synchronous to the system clock
    input  wire logic       OSC_TICK_I,
    // Compare output pins
    output logic            CMP_OUT_A_O,
    output logic            CMP_OUT_A_OE_O,
    output logic            CMP_OUT_B_O,
    output logic            CMP_OUT_B_OE_O,
    // Overflow flag level
    output logic            OVERFLOW_O
);
    logic [7:0]        ctrl_a_q;
    logic              mode_hi_q;
    logic [7:0]        count_q;
    logic [7:0]        count_d;
    logic              down_q;
    logic              down_d;
    logic [7:0]        cmp_a_q;
    logic [7:0]        cmp_b_q;
    logic [7:0]        buf_a_q;
    logic [7:0]        buf_b_q;
    logic              ovf_q;
    logic [3:0]        pre_q;
    logic [1:0]        dir_q;
    logic              block_q;
    logic              tick;
    logic [2:0]        wave_mode_sel;
    wave_pkg::kind_t   kind;
    logic [7:0]        top;
    logic              ovf_set;
    logic              force_a;
    logic              force_b;
    logic              out_a;
    logic              out_b;
    logic [1:0]        out_a_action;
    logic [1:0]        out_b_action;
    wave_pkg::cnt_evt_t evt;

    assign out_a_action  = ctrl_a_q[wave_pkg::POS_ACT_A +: 2];
    assign out_b_action  = ctrl_a_q[wave_pkg::POS_ACT_B +: 2];
    assign wave_mode_sel = {mode_hi_q, ctrl_a_q[wave_pkg::POS_MODE_LO +: 2]};

    // ********************************************************
    // Mode decode
    // ********************************************************
    always_comb
    begin
        case (wave_mode_sel)
            3'h1, 3'h5: kind = wave_pkg::KIND_DUAL;
            3'h3, 3'h7: kind = wave_pkg::KIND_FAST;
            3'h2:       kind = wave_pkg::KIND_CTC;
            default:    kind = wave_pkg::KIND_NORMAL;
        endcase
    end

    // Modes 4 to 7 and CTC use compare A as ceiling, others the fixed MAX
    assign top = (wave_mode_sel[2] || wave_mode_sel == 3'h2) ? cmp_a_q : wave_pkg::MAX;

    // ********************************************************
    // Tick source
    // ********************************************************
    wave_prescaler u_pre (
        .clk_i      (SYS_CLK_I),
        .rst_i      (RST_I),
        .sel_i      (pre_q[2:0]),
        .async_i    (pre_q[wave_pkg::POS_ASYNC]),
        .osc_tick_i (OSC_TICK_I),
        .tick_o     (tick)
    );

    // ********************************************************
    // Counter sequence
    // ********************************************************
    always_comb
    begin
        count_d = count_q;
        down_d  = down_q;
        ovf_set = 1'b0;
        if (tick)
        begin
            if (kind == wave_pkg::KIND_DUAL)
            begin
                // Ceiling held one tick, then direction flips
                if (!down_q && count_q >= top)
                begin
                    down_d  = 1'b1;
                    count_d = count_q - 8'h01;
                end
                else if (down_q && count_q == wave_pkg::BOTTOM)
                begin
                    down_d  = 1'b0;
                    count_d = 8'h01;
                end
                else
                begin
                    count_d = down_q ? count_q - 8'h01 : count_q + 8'h01;
                    if (down_q && count_q == 8'h01)
                        ovf_set = 1'b1;
                end
            end
            else
            begin
                down_d = 1'b0;
                if ((kind != wave_pkg::KIND_NORMAL) && count_q == top)
                    count_d = wave_pkg::BOTTOM;
                else
                    count_d = count_q + 8'h01;
                if (kind == wave_pkg::KIND_FAST)
                    ovf_set = (count_q == top);
                else
                    ovf_set = (count_q == wave_pkg::MAX);
            end
        end
    end

    // Counter register; a software write wins over counting
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            count_q <= 8'h00;
            down_q  <= 1'b0;
        end
        else if (WR_I && ADDR_I == wave_pkg::OFF_COUNT)
        begin
            count_q <= WDATA_I;
            down_q  <= down_q;
        end
        else
        begin
            count_q <= count_d;
            down_q  <= down_d;
        end
    end

    // Written counter blocks the match on the next tick
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
            block_q <= 1'b0;
        else if (WR_I && ADDR_I == wave_pkg::OFF_COUNT)
            block_q <= 1'b1;
        else if (tick)
            block_q <= 1'b0;
    end

    // ********************************************************
    // Control registers
    // ********************************************************
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ctrl_a_q  <= wave_pkg::CTRL_A_RST;
            mode_hi_q <= 1'b0;
            pre_q     <= 4'h0;
            dir_q     <= 2'h0;
        end
        else if (WR_I)
        begin
            if (ADDR_I == wave_pkg::OFF_CTRL_A)
                ctrl_a_q <= WDATA_I & wave_pkg::CTRL_A_WMASK;
            else if (ADDR_I == wave_pkg::OFF_CTRL_B)
                mode_hi_q <= WDATA_I[wave_pkg::POS_MODE_HI];
            else if (ADDR_I == wave_pkg::OFF_PRESCALE)
                pre_q <= WDATA_I[3:0];
            else if (ADDR_I == wave_pkg::OFF_DIR)
                dir_q <= WDATA_I[1:0];
        end
    end

    // Force strobes act only outside the PWM modes
    assign force_a = WR_I && ADDR_I == wave_pkg::OFF_CTRL_B && WDATA_I[wave_pkg::POS_FORCE_A]
                     && kind != wave_pkg::KIND_DUAL && kind != wave_pkg::KIND_FAST;
    assign force_b = WR_I && ADDR_I == wave_pkg::OFF_CTRL_B && WDATA_I[wave_pkg::POS_FORCE_B]
                     && kind != wave_pkg::KIND_DUAL && kind != wave_pkg::KIND_FAST;

    // ********************************************************
    // Compare registers with double buffer
    // ********************************************************
    // Writes land in the buffer; PWM loads at the ceiling to avoid glitches
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            buf_a_q <= 8'h00;
            buf_b_q <= 8'h00;
        end
        else if (WR_I && ADDR_I == wave_pkg::OFF_CMP_A)
            buf_a_q <= WDATA_I;
        else if (WR_I && ADDR_I == wave_pkg::OFF_CMP_B)
            buf_b_q <= WDATA_I;
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            cmp_a_q <= 8'h00;
            cmp_b_q <= 8'h00;
        end
        else if (kind != wave_pkg::KIND_DUAL && kind != wave_pkg::KIND_FAST)
        begin
            cmp_a_q <= buf_a_q;
            cmp_b_q <= buf_b_q;
        end
        else if (tick && count_q == top && !down_q)
        begin
            cmp_a_q <= buf_a_q;
            cmp_b_q <= buf_b_q;
        end
    end

    // ********************************************************
    // Overflow flag, set wins over write-one clear
    // ********************************************************
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
            ovf_q <= 1'b0;
        else if (ovf_set)
            ovf_q <= 1'b1;
        else if (WR_I && ADDR_I == wave_pkg::OFF_STATUS && WDATA_I[0])
            ovf_q <= 1'b0;
    end

    // ********************************************************
    // Output channels
    // ********************************************************
    assign evt.tick      = tick;
    assign evt.dir_down  = down_q;
    assign evt.at_top    = (count_q == top);
    assign evt.at_bottom = (count_q == wave_pkg::BOTTOM);
    assign evt.count     = count_q;
    assign evt.top       = top;

    wave_channel #(.IS_A(1'b1)) u_ch_a (
        .clk_i     (SYS_CLK_I),
        .rst_i     (RST_I),
        .evt_i     (evt),
        .kind_i    (kind),
        .mode_hi_i (mode_hi_q),
        .act_i     (out_a_action),
        .cmp_i     (cmp_a_q),
        .force_i   (force_a),
        .block_i   (block_q),
        .out_o     (out_a)
    );

    wave_channel #(.IS_A(1'b0)) u_ch_b (
        .clk_i     (SYS_CLK_I),
        .rst_i     (RST_I),
        .evt_i     (evt),
        .kind_i    (kind),
        .mode_hi_i (mode_hi_q),
        .act_i     (out_b_action),
        .cmp_i     (cmp_b_q),
        .force_i   (force_b),
        .block_i   (block_q),
        .out_o     (out_b)
    );

    // Pin drive registered; enable needs a nonzero action and direction out
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            CMP_OUT_A_O    <= 1'b0;
            CMP_OUT_A_OE_O <= 1'b0;
            CMP_OUT_B_O    <= 1'b0;
            CMP_OUT_B_OE_O <= 1'b0;
            OVERFLOW_O     <= 1'b0;
        end
        else
        begin
            CMP_OUT_A_O    <= out_a;
            CMP_OUT_A_OE_O <= (out_a_action != wave_pkg::ACT_OFF) && dir_q[0];
            CMP_OUT_B_O    <= out_b;
            CMP_OUT_B_OE_O <= (out_b_action != wave_pkg::ACT_OFF) && dir_q[1];
            OVERFLOW_O     <= ovf_q;
        end
    end

    // ********************************************************
    // Read port, data one cycle after the strobe
    // ********************************************************
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
            RDATA_O <= 8'h00;
        else if (RD_I)
        begin
            if (ADDR_I == wave_pkg::OFF_CTRL_A)
                RDATA_O <= ctrl_a_q;
            else if (ADDR_I == wave_pkg::OFF_CTRL_B)
                RDATA_O <= {4'h0, mode_hi_q, 3'h0};
            else if (ADDR_I == wave_pkg::OFF_COUNT)
                RDATA_O <= count_q;
            else if (ADDR_I == wave_pkg::OFF_CMP_A)
                RDATA_O <= buf_a_q;
            else if (ADDR_I == wave_pkg::OFF_CMP_B)
                RDATA_O <= buf_b_q;
            else if (ADDR_I == wave_pkg::OFF_STATUS)
                RDATA_O <= {6'h00, down_q, ovf_q};
            else if (ADDR_I == wave_pkg::OFF_PRESCALE)
                RDATA_O <= {4'h0, pre_q};
            else
                RDATA_O <= {6'h00, dir_q};
        end
        else
            RDATA_O <= 8'h00;
    end
endmodule

/* tb/wave_load.sv */
`timescale 1ns/1ns
// ****
// Pin load
// ****
// The line has a pull-down, so an undriven pin reads low
module wave_load (
    // Driver side
    input  wire logic level_i,
    input  wire logic oe_i,
    // Level at the load
    output logic      pin_o
);
    assign pin_o = oe_i ? level_i : 1'b0;
endmodule

/* tb/wave_timer_sva.sv */
`timescale 1ns/1ns
// ****
// Pin and register checks
// ****
module wave_timer_sva (
    // Clock, reset, register port
    input wire logic       SYS_CLK_I,
    input wire logic       RST_I,
    input wire logic [2:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RDATA_O,
    // Pins
    input wire logic       OSC_TICK_I,
    input wire logic       CMP_OUT_A_O,
    input wire logic       CMP_OUT_A_OE_O,
    input wire logic       CMP_OUT_B_O,
    input wire logic       CMP_OUT_B_OE_O,
    input wire logic       OVERFLOW_O
);
    logic [7:0] ctl_q;
    logic [2:0] sel_q;
    logic [1:0] dir_q;
    logic       stop_q;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    // Shadow fields; stop_q means prescale select 0 (no tick unless async is set) and no mode or action change
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ctl_q  <= 8'h00;
            sel_q  <= 3'h0;
            dir_q  <= 2'h0;
            stop_q <= 1'b0;
        end
        else
        begin
            if (WR_I && ADDR_I == wave_pkg::OFF_CTRL_A)
                ctl_q <= WDATA_I & wave_pkg::CTRL_A_WMASK;
            if (WR_I && ADDR_I == wave_pkg::OFF_PRESCALE)
                sel_q <= WDATA_I[2:0];
            if (WR_I && ADDR_I == wave_pkg::OFF_DIR)
                dir_q <= WDATA_I[1:0];
            stop_q <= sel_q == 3'h0 && !(WR_I && ADDR_I inside
                {wave_pkg::OFF_CTRL_A, wave_pkg::OFF_CTRL_B, wave_pkg::OFF_PRESCALE});
        end
    end
    sequence s_ctl_rd;
        RD_I && ADDR_I == wave_pkg::OFF_CTRL_A;
    endsequence
    sequence s_cnt_wr_rd;
        WR_I && ADDR_I == wave_pkg::OFF_COUNT && stop_q ##2 RD_I && ADDR_I == wave_pkg::OFF_COUNT;
    endsequence
    property p_ctl_rd;
        s_ctl_rd |=> RDATA_O == ctl_q;
    endproperty
    property p_cnt_rd;
        s_cnt_wr_rd |=> RDATA_O == $past(WDATA_I, 3);
    endproperty
    property p_dir_rd;
        RD_I && ADDR_I == wave_pkg::OFF_DIR |=> RDATA_O[1:0] == dir_q;
    endproperty
    property p_oe_a;
        !$past(WR_I) |-> CMP_OUT_A_OE_O == (ctl_q[7:6] != 2'h0 && dir_q[0]);
    endproperty
    property p_oe_b;
        !$past(WR_I) |-> CMP_OUT_B_OE_O == (ctl_q[5:4] != 2'h0 && dir_q[1]);
    endproperty
    // Three quiet cycles cover the prescaler and pin register latency
    property p_hold_a;
        stop_q && $past(stop_q) && $past(stop_q, 2) |-> $stable(CMP_OUT_A_O);
    endproperty
    property p_hold_b;
        stop_q && $past(stop_q) && $past(stop_q, 2) |-> $stable(CMP_OUT_B_O);
    endproperty
    property p_ovf_clr;
        WR_I && ADDR_I == wave_pkg::OFF_STATUS && WDATA_I[0] && stop_q |-> ##[1:2] !OVERFLOW_O;
    endproperty
    a_ctl_rd:  assert property (p_ctl_rd)  else $error("control A readback wrong");
    a_cnt_rd:  assert property (p_cnt_rd)  else $error("count readback wrong");
    a_dir_rd:  assert property (p_dir_rd)  else $error("direction readback wrong");
    a_oe_a:    assert property (p_oe_a)    else $error("pin A enable wrong");
    a_oe_b:    assert property (p_oe_b)    else $error("pin B enable wrong");
    a_hold_a:  assert property (p_hold_a)  else $error("pin A moved while stopped");
    a_hold_b:  assert property (p_hold_b)  else $error("pin B moved while stopped");
    a_ovf_clr: assert property (p_ovf_clr) else $error("overflow not cleared");
endmodule
bind wave_timer wave_timer_sva chk (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .OSC_TICK_I(OSC_TICK_I),
    .CMP_OUT_A_O(CMP_OUT_A_O), .CMP_OUT_A_OE_O(CMP_OUT_A_OE_O), .CMP_OUT_B_O(CMP_OUT_B_O),
    .CMP_OUT_B_OE_O(CMP_OUT_B_OE_O), .OVERFLOW_O(OVERFLOW_O));

/* tb/test_wave_timer.sv */
`timescale 1ns/1ns
// ****
// Waveform timer bench
// ****
module test_wave_timer;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata, d;
    logic       out_a, oe_a, out_b, oe_b, ovf, pin_a, pin_b;
    int         fails = 0;
    int         n_tests = 0;
    int         hi, lo;
    always #20 clk = ~clk;
    wave_timer dut (.SYS_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .OSC_TICK_I(1'b0), .CMP_OUT_A_O(out_a),
        .CMP_OUT_A_OE_O(oe_a), .CMP_OUT_B_O(out_b), .CMP_OUT_B_OE_O(oe_b), .OVERFLOW_O(ovf));
    wave_load load_a (.level_i(out_a), .oe_i(oe_a), .pin_o(pin_a));
    wave_load load_b (.level_i(out_b), .oe_i(oe_b), .pin_o(pin_b));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask
    // A gap cycle after each strobe keeps every signal to one change per step
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [2:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask
    task automatic wait_lvl(input bit b, input logic v, output int n);
        n = 0;
        while ((b ? out_b : out_a) !== v)
        begin
            @(posedge clk);
            #1 n++;
            if (n > 1100)
            begin
                fails++;
                wrap_up();
            end
        end
    endtask
    // Skips the first period, where buffered compares may still settle
    task automatic measure(input bit b);
        int n;
        wait_lvl(b, 1'b1, n);
        wait_lvl(b, 1'b0, n);
        wait_lvl(b, 1'b1, n);
        wait_lvl(b, 1'b0, hi);
        wait_lvl(b, 1'b1, lo);
    endtask
    task automatic arm(input logic [7:0] ctl, input logic top_bit, input logic [7:0] ca, cb);
        wr_reg(wave_pkg::OFF_PRESCALE, 8'h00);
        wr_reg(wave_pkg::OFF_CTRL_A, 8'h00);
        wr_reg(wave_pkg::OFF_CTRL_B, 8'h00);
        wr_reg(wave_pkg::OFF_COUNT, 8'h00);
        wr_reg(wave_pkg::OFF_CMP_A, ca);
        wr_reg(wave_pkg::OFF_CMP_B, cb);
        wr_reg(wave_pkg::OFF_CTRL_A, ctl);
        wr_reg(wave_pkg::OFF_CTRL_B, {4'h0, top_bit, 3'h0});
        wr_reg(wave_pkg::OFF_DIR, 8'h03);
        wr_reg(wave_pkg::OFF_PRESCALE, 8'h01);
    endtask
    task automatic t_regs;
        rd_reg(wave_pkg::OFF_CTRL_A);
        check(d, wave_pkg::CTRL_A_RST);
        wr_reg(wave_pkg::OFF_CTRL_A, 8'hff);
        rd_reg(wave_pkg::OFF_CTRL_A);
        check(d, 8'hf3);
        wr_reg(wave_pkg::OFF_COUNT, 8'h5a);
        rd_reg(wave_pkg::OFF_COUNT);
        check(d, 8'h5a);
    endtask
    task automatic t_dual;
        arm(8'hb1, 1'b0, 8'h80, 8'h80);
        measure(1'b0);
        check(hi[15:0], 16'h0100);
        check(lo[15:0], 16'h00fe);
        check(16'(hi + lo), 16'(wave_pkg::PERIOD_FIXED));
        check({pin_a, pin_b}, {out_a, out_b});
        measure(1'b1);
        check(hi[15:0], 16'h00fe);
        check(lo[15:0], 16'h0100);
        rd_reg(wave_pkg::OFF_STATUS);
        check({d[0], ovf}, 2'b11);
        wr_reg(wave_pkg::OFF_PRESCALE, 8'h00);
        wr_reg(wave_pkg::OFF_STATUS, 8'h01);
        rd_reg(wave_pkg::OFF_STATUS);
        check({d[0], ovf}, 2'b00);
    endtask
    task automatic t_ceil;
        arm(8'h21, 1'b1, 8'h40, 8'h20);
        measure(1'b1);
        check(hi[15:0], 16'h0040);
        check(lo[15:0], 16'h0040);
    endtask
    task automatic t_extreme;
        arm(8'ha1, 1'b0, 8'h00, 8'hff);
        repeat (600) @(posedge clk);
        repeat (520)
        begin
            @(posedge clk);
            #1 check({out_a, out_b}, 16'h0001);
        end
    endtask
    // Fast PWM: set at the ceiling, clear at 0x40, so high for counts 0 to 0x40
    task automatic t_fast;
        arm(8'h83, 1'b0, 8'h40, 8'h00);
        measure(1'b0);
        check(hi[15:0], 16'h0041);
        check(lo[15:0], 16'h00bf);
    endtask
    // Set, clear, then toggle from low: the level always equals the low code bit
    task automatic t_force;
        logic [1:0] k;
        arm(8'h00, 1'b0, 8'h10, 8'h10);
        wr_reg(wave_pkg::OFF_PRESCALE, 8'h00);
        for (int i = 3; i > 0; i--)
        begin
            k = i[1:0];
            wr_reg(wave_pkg::OFF_CTRL_A, {k, k, 4'h0});
            wr_reg(wave_pkg::OFF_CTRL_B, 8'hc0);
            #1 check({out_a, out_b, oe_a, oe_b}, {k[0], k[0], 2'b11});
        end
        wr_reg(wave_pkg::OFF_DIR, 8'h01);
        rd_reg(wave_pkg::OFF_DIR);
        #1 check({d, oe_a, oe_b, pin_b}, {8'h01, 3'b100});
        wr_reg(wave_pkg::OFF_CTRL_A, 8'h00);
        #1 check({oe_a, pin_a}, 2'b00);
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_dual();
        t_ceil();
        t_extreme();
        t_fast();
        t_force();
        wrap_up();
    end
endmodule
